//--- design/tmcr_defines.svh
`ifndef TMCR_DEFINES_SVH
`define TMCR_DEFINES_SVH
// ----------------------------------------------------------------
// Register map, byte addresses on the AHB-Lite port
// ----------------------------------------------------------------
`define TMCR_ADDR_CFG 8'h00
`define TMCR_ADDR_LASTINFO 8'h04
`define TMCR_ADDR_TIMETAG 8'h08
`define TMCR_ADDR_COUNT 8'h0C
`define TMCR_ADDR_STATE 8'h10
// ----------------------------------------------------------------
// Configuration register fields and reset value
// ----------------------------------------------------------------
`define TMCR_CFG_GLOBAL_BUSY 0
`define TMCR_CFG_UMC_INV 1
`define TMCR_CFG_BCAST_SEL 3
`define TMCR_CFG_W 4
`define TMCR_CFG_RST 4'h0
// ----------------------------------------------------------------
// Information word fields
// ----------------------------------------------------------------
`define TMCR_IW_GAPBC 13
`define TMCR_IW_WCNT 12
`define TMCR_IW_MESSAGE_ERROR_FLAG 10
`define TMCR_IW_BUSY 9
`define TMCR_IW_ILL 8
`define TMCR_IW_BUS_IDENTITY_BIT 5
`define TMCR_IW_MC_HI 4
`define TMCR_IW_MC_LO 0
// ----------------------------------------------------------------
// Record layout and mode codes
// ----------------------------------------------------------------
`define TMCR_OFS_TAG 13'h0001
`define TMCR_OFS_DATA 13'h0002
`define TMCR_MC_DATA_BIT 4
`define TMCR_MC_LASTCMD 5'h12
`define TMCR_MC_BITWORD 5'h13
`define TMCR_MC_UNDEF_A 5'h11
`define TMCR_MC_UNDEF_B 5'h14
`define TMCR_MC_UNDEF_C 5'h15
`define TMCR_WORD_ZERO 16'h0000
`define TMCR_ADDR_ZERO 13'h0000
`define TMCR_BUS_ZERO 32'h0000_0000
`endif

//--- design/tmcr_pkg.sv
package tmcr_pkg;
  // Command information handed over when a transmit mode command is decoded.
  typedef struct packed {
    logic [4:0] modeCode;
    logic busB;
    logic broadcast;
    logic cmdBusy;
    logic illegal;
    logic [12:0] dataPtr;
  } tmcr_cmd_t;
  // Error observations reported when the message is over.
  typedef struct packed {
    logic gapSeen;
    logic extraWord;
  } tmcr_done_t;
  // Record engine states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_LOAD, ST_SEND, ST_WAITD, ST_WINFO, ST_WTAG, ST_WDATA
  } tmcr_state_t;
endpackage

//--- design/tmcr_record.sv
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "tmcr_defines.svh"
module tmcr_record
  import tmcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cmdStart,
  input wire tmcr_cmd_t cmdInfo,
  input wire logic msgDone,
  input wire tmcr_done_t doneInfo,
  input wire logic [15:0] lastCmdWord,
  input wire logic [15:0] bitWord,
  output logic txValid,
  output logic [15:0] txData,
  output logic ramRe,
  output logic ramWe,
  output logic [12:0] ramAddr,
  output logic [15:0] ramWrData,
  input wire logic [15:0] ramRdData
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // True for the codes whose data word the block makes itself.
  function automatic logic isInternal(input logic [4:0] mc);
    isInternal = (mc == `TMCR_MC_LASTCMD) || (mc == `TMCR_MC_BITWORD);
  endfunction

  // True for the data-carrying codes that have no defined meaning.
  function automatic logic isUndef(input logic [4:0] mc);
    isUndef = (mc == `TMCR_MC_UNDEF_A) || (mc == `TMCR_MC_UNDEF_B) ||
              (mc == `TMCR_MC_UNDEF_C);
  endfunction

  // Builds the information word; unused bits stay zero.
  function automatic logic [15:0] mkInfo(input tmcr_cmd_t c, input tmcr_done_t d,
                                         input logic busy, input logic bcSel);
    logic [15:0] w;
    logic gapBc;
    w = `TMCR_WORD_ZERO;
    gapBc = bcSel ? c.broadcast : d.gapSeen;
    w[`TMCR_IW_GAPBC] = gapBc;
    w[`TMCR_IW_WCNT] = d.extraWord;
    w[`TMCR_IW_MESSAGE_ERROR_FLAG] = d.extraWord | (d.gapSeen & ~bcSel);
    w[`TMCR_IW_BUSY] = busy;
    w[`TMCR_IW_ILL] = c.illegal;
    w[`TMCR_IW_BUS_IDENTITY_BIT] = c.busB;
    w[`TMCR_IW_MC_HI:`TMCR_IW_MC_LO] = c.modeCode;
    mkInfo = w;
  endfunction

  // ----------------------------------------------------------------
  // Register and engine state
  // ----------------------------------------------------------------
  logic [`TMCR_CFG_W-1:0] cfg;
  logic [15:0] timeTag;
  logic [15:0] lastInfo;
  logic [15:0] recCount;
  tmcr_state_t state;
  tmcr_cmd_t cmdR;
  logic [15:0] tagR;
  logic [15:0] txWord;
  logic busyR;
  logic sentR;
  logic wrPend;
  logic [7:0] wrAddr;
  logic busAct;
  logic [31:0] next_hrdata;
  logic startBusy;
  logic startOk;

  // A valid NONSEQ or SEQ transfer addressed to this slave.
  assign busAct = hsel && htrans[1] && hready;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------

  // The slave never stalls and never errors.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Write address is held for the data phase.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= busAct && hwrite;
      wrAddr <= haddr[7:0];
    end
  end

  // Configuration register takes the data phase word.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= `TMCR_CFG_RST;
    end else if (wrPend && wrAddr == `TMCR_ADDR_CFG) begin
      cfg <= hwdata[`TMCR_CFG_W-1:0];
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    case (haddr[7:0])
      `TMCR_ADDR_CFG: next_hrdata = {28'h0000000, cfg};
      `TMCR_ADDR_LASTINFO: next_hrdata = {16'h0000, lastInfo};
      `TMCR_ADDR_TIMETAG: next_hrdata = {16'h0000, timeTag};
      `TMCR_ADDR_COUNT: next_hrdata = {16'h0000, recCount};
      `TMCR_ADDR_STATE: next_hrdata = {29'h00000000, state};
      default: next_hrdata = `TMCR_BUS_ZERO;
    endcase
  end

  // Read data is registered so it stands in the data phase.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= `TMCR_BUS_ZERO;
    end else if (busAct && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Time tag counter
  // ----------------------------------------------------------------

  // Free-running counter, one count per clock.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timeTag <= `TMCR_WORD_ZERO;
    end else begin
      timeTag <= timeTag + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Record engine
  // ----------------------------------------------------------------

  // Busy answer from the global bit or the per-command bit.
  assign startBusy = cfg[`TMCR_CFG_GLOBAL_BUSY] | cmdInfo.cmdBusy;
  // Data is sent only if legal, not busy and not an invalidated undefined code.
  assign startOk = cmdInfo.modeCode[`TMCR_MC_DATA_BIT] && !startBusy &&
                   !cmdInfo.illegal &&
                   !(isUndef(cmdInfo.modeCode) && cfg[`TMCR_CFG_UMC_INV]);

  // Sequencing of fetch, transmit and record writes.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cmdR <= '0;
      tagR <= `TMCR_WORD_ZERO;
      txWord <= `TMCR_WORD_ZERO;
      busyR <= 1'b0;
      sentR <= 1'b0;
      ramRe <= 1'b0;
      ramWe <= 1'b0;
      ramAddr <= `TMCR_ADDR_ZERO;
      ramWrData <= `TMCR_WORD_ZERO;
      txValid <= 1'b0;
      txData <= `TMCR_WORD_ZERO;
    end else begin
      case (state)
        ST_IDLE: begin
          ramWe <= 1'b0;
          sentR <= 1'b0;
          if (cmdStart) begin
            cmdR <= cmdInfo;
            tagR <= timeTag;
            busyR <= startBusy;
            if (startOk && isInternal(cmdInfo.modeCode)) begin
              txWord <= (cmdInfo.modeCode == `TMCR_MC_LASTCMD) ? lastCmdWord : bitWord;
              state <= ST_SEND;
            end else if (startOk) begin
              ramRe <= 1'b1;
              ramAddr <= cmdInfo.dataPtr + `TMCR_OFS_DATA;
              state <= ST_FETCH;
            end else begin
              state <= ST_WAITD;
            end
          end
        end
        ST_FETCH: begin
          ramRe <= 1'b0;
          state <= ST_LOAD;
        end
        ST_LOAD: begin
          txWord <= ramRdData;
          state <= ST_SEND;
        end
        ST_SEND: begin
          txValid <= 1'b1;
          txData <= txWord;
          sentR <= 1'b1;
          state <= ST_WAITD;
        end
        ST_WAITD: begin
          txValid <= 1'b0;
          if (msgDone) begin
            ramWe <= 1'b1;
            ramAddr <= cmdR.dataPtr;
            ramWrData <= mkInfo(cmdR, doneInfo, busyR, cfg[`TMCR_CFG_BCAST_SEL]);
            state <= ST_WINFO;
          end
        end
        ST_WINFO: begin
          ramAddr <= cmdR.dataPtr + `TMCR_OFS_TAG;
          ramWrData <= tagR;
          state <= ST_WTAG;
        end
        ST_WTAG: begin
          if (isInternal(cmdR.modeCode) && sentR) begin
            ramAddr <= cmdR.dataPtr + `TMCR_OFS_DATA;
            ramWrData <= txWord;
            state <= ST_WDATA;
          end else begin
            ramWe <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_WDATA: begin
          ramWe <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Last information word and record count for software.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lastInfo <= `TMCR_WORD_ZERO;
      recCount <= `TMCR_WORD_ZERO;
    end else if (state == ST_WINFO) begin
      lastInfo <= ramWrData;
      recCount <= recCount + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  recordAddrs_a: assert property (
    (state == ST_WAITD && msgDone) |=>
      (ramWe && ramAddr == cmdR.dataPtr) ##1
      (ramWe && ramAddr == cmdR.dataPtr + `TMCR_OFS_TAG))
    else $error("Record words not at pointer and pointer plus one.");

  echoWrite_a: assert property (
    (state == ST_WDATA) |->
      (ramWe && ramAddr == cmdR.dataPtr + `TMCR_OFS_DATA && ramWrData == txWord &&
       isInternal(cmdR.modeCode)))
    else $error("Internal data word not stored at plus two.");

  writeAfterDone_a: assert property (
    $rose(ramWe) |-> $past(state) == ST_WAITD && $past(msgDone))
    else $error("Record written before completion.");

  noThirdWord_a: assert property (
    (state == ST_WTAG && !cmdR.modeCode[`TMCR_MC_DATA_BIT]) |=> !ramWe)
    else $error("Third word written for a code without data.");

  undefInForm_a: assert property (
    (state == ST_IDLE && cmdStart && isUndef(cmdInfo.modeCode) && !cmdInfo.illegal &&
     !cmdInfo.cmdBusy && !cfg[`TMCR_CFG_GLOBAL_BUSY] && !cfg[`TMCR_CFG_UMC_INV])
      |-> ##[3:4] txValid)
    else $error("Undefined code did not answer in form.");

  invalidUndef_a: assert property (
    (state == ST_IDLE && cmdStart && isUndef(cmdInfo.modeCode) && cfg[`TMCR_CFG_UMC_INV])
      |=> state == ST_WAITD)
    else $error("Invalidated undefined code was fetched.");

  busyNoData_a: assert property (
    (state == ST_IDLE && cmdStart && startBusy) |=> !txValid [*3])
    else $error("Data word sent under busy.");

  infoFields_a: assert property (
    (state == ST_WINFO) |->
      ramWrData[`TMCR_IW_MC_HI:`TMCR_IW_MC_LO] == cmdR.modeCode &&
      ramWrData[`TMCR_IW_BUS_IDENTITY_BIT] == cmdR.busB && ramWrData[`TMCR_IW_ILL] == cmdR.illegal &&
      ramWrData[`TMCR_IW_BUSY] == busyR)
    else $error("Info word fields do not match the command.");

  errorBits_a: assert property (
    (state == ST_WINFO) |->
      ramWrData[`TMCR_IW_MESSAGE_ERROR_FLAG] == (ramWrData[`TMCR_IW_WCNT] |
        (ramWrData[`TMCR_IW_GAPBC] & ~cfg[`TMCR_CFG_BCAST_SEL])) &&
      ramWrData[15:14] == 2'h0 && ramWrData[11] == 1'b0 && ramWrData[7:6] == 2'h0)
    else $error("Error or unused bits wrong.");

  gapSelect_a: assert property (
    (state == ST_WAITD && msgDone) |=>
      ramWrData[`TMCR_IW_GAPBC] == ($past(cfg[`TMCR_CFG_BCAST_SEL]) ?
        cmdR.broadcast : $past(doneInfo.gapSeen)) &&
      ramWrData[`TMCR_IW_WCNT] == $past(doneInfo.extraWord))
    else $error("Bit 13 or bit 12 wrong.");

  tagWord_a: assert property (
    (state == ST_WTAG) |-> (ramWe && ramAddr == cmdR.dataPtr + `TMCR_OFS_TAG &&
      ramWrData == tagR))
    else $error("Time tag word not written at plus one.");

  tagCapture_a: assert property (
    (state == ST_IDLE && cmdStart) |=> tagR == $past(timeTag))
    else $error("Time tag not caught at command start.");

  coverEcho_c: cover property (state == ST_WDATA);
  coverFetch_c: cover property (state == ST_LOAD ##1 state == ST_SEND);
  coverNoData_c: cover property (state == ST_WTAG ##1 state == ST_IDLE);
  coverBusy_c: cover property (state == ST_WINFO && busyR);

endmodule

//--- tb/tmcr_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus controller and record RAM seen from the record engine
// ----------------------------------------------------------------
module tmcr_bus_model
  import tmcr_pkg::*;
(
  input wire logic core_clk,
  output logic cmdStart,
  output tmcr_cmd_t cmdInfo,
  output logic msgDone,
  output tmcr_done_t doneInfo,
  input wire logic txValid,
  input wire logic [15:0] txData,
  input wire logic ramRe,
  input wire logic ramWe,
  input wire logic [12:0] ramAddr,
  input wire logic [15:0] ramWrData,
  output logic [15:0] ramRdData
);
  logic [15:0] mem [8192];
  logic [15:0] rdq = 16'h0000;
  logic rdValid = 1'b0;
  int txCnt = 0;
  logic [15:0] txLast = 16'h0000;
  initial begin
    cmdStart = 1'b0;
    cmdInfo = '0;
    msgDone = 1'b0;
    doneInfo = '0;
  end
  // RAM answers the cycle after a read; outside that the bus shows scrambled data.
  always @(posedge core_clk) begin
    if (ramWe) begin
      mem[ramAddr] <= ramWrData;
    end
    rdValid <= ramRe;
    if (ramRe) begin
      rdq <= mem[ramAddr];
    end
  end
  assign ramRdData = rdValid ? rdq : ~rdq;
  // Counts every mode data word sent on the serial bus.
  always @(posedge core_clk) begin
    if (txValid) begin
      txCnt <= txCnt + 1;
      txLast <= txData;
    end
  end
  // One mode command: decode pulse, message end pulse, then wait for the record writes.
  task automatic issue(input tmcr_cmd_t c, input tmcr_done_t d);
    int n;
    n = 0;
    @(posedge core_clk);
    cmdStart <= 1'b1;
    cmdInfo <= c;
    @(posedge core_clk);
    cmdStart <= 1'b0;
    cmdInfo <= ~c;
    repeat (6) @(posedge core_clk);
    msgDone <= 1'b1;
    doneInfo <= d;
    @(posedge core_clk);
    msgDone <= 1'b0;
    doneInfo <= ~d;
    while (ramWe !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    while (ramWe === 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
  endtask
endmodule

//--- tb/tmcr_record_bench.sv
`timescale 1ns/1ps
`include "tmcr_defines.svh"
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin errTotal++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
// ----------------------------------------------------------------
// Self-checking bench for the transmit mode record engine
// ----------------------------------------------------------------
module tmcr_record_bench;
  import tmcr_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, txValid, ramRe, ramWe, cmdStart, msgDone;
  logic [31:0] hrdata;
  logic [15:0] lastCmdWord = 16'hA5C3;
  logic [15:0] bitWord = 16'h5A3C;
  logic [15:0] txData, ramWrData, ramRdData, lastIw;
  logic [12:0] ramAddr;
  logic [15:0] tagRef = 16'h0000;
  logic [15:0] tagCap = 16'h0000;
  tmcr_cmd_t cmdInfo;
  tmcr_done_t doneInfo;
  int errTotal = 0;
  int checkCount = 0;
  int cycles = 0;
  int caseNo = 0;
  logic [31:0] rd;
  always #12.5 core_clk = ~core_clk;
  tmcr_record dut_u (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmdStart(cmdStart),
    .cmdInfo(cmdInfo), .msgDone(msgDone), .doneInfo(doneInfo), .lastCmdWord(lastCmdWord),
    .bitWord(bitWord), .txValid(txValid), .txData(txData), .ramRe(ramRe), .ramWe(ramWe),
    .ramAddr(ramAddr), .ramWrData(ramWrData), .ramRdData(ramRdData));
  tmcr_bus_model model_u (.core_clk(core_clk), .cmdStart(cmdStart), .cmdInfo(cmdInfo),
    .msgDone(msgDone), .doneInfo(doneInfo), .txValid(txValid), .txData(txData),
    .ramRe(ramRe), .ramWe(ramWe), .ramAddr(ramAddr), .ramWrData(ramWrData),
    .ramRdData(ramRdData));
  // Prints the counts and the verdict, then stops the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      tally_and_finish();
    end
  end
  // Reference time tag: counts every edge out of reset and is caught at each command start.
  always @(posedge core_clk) begin
    if (rstn) begin
      tagRef <= tagRef + 16'h0001;
    end
    if (cmdStart) begin
      tagCap <= tagRef;
    end
  end
  // One single AHB-Lite word transfer; read data is taken at the data phase edge.
  task automatic ahbXfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                         output logic [31:0] rdv);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  // Flags are {busB, broadcast, cmdBusy, illegal, gapSeen, extraWord}.
  task automatic runCase(input logic [3:0] cfg, input logic [4:0] mc, input logic [5:0] f);
    logic [15:0] iw, pre, gen;
    logic [12:0] ptr;
    logic tx, busyF, own;
    int c0;
    ptr = 13'h1500 + 13'(caseNo * 4);
    pre = 16'h1000 + 16'(caseNo);
    gen = (mc == `TMCR_MC_LASTCMD) ? lastCmdWord : bitWord;
    own = (mc == `TMCR_MC_LASTCMD) || (mc == `TMCR_MC_BITWORD);
    model_u.mem[ptr] = 16'hFFFF;
    model_u.mem[ptr + 13'h0001] = 16'hFFFF;
    model_u.mem[ptr + 13'h0002] = pre;
    ahbXfer(1'b1, {24'h0, `TMCR_ADDR_CFG}, {28'h0, cfg}, rd);
    busyF = cfg[0] | f[3];
    tx = mc[4] & !busyF & !f[2] & !(cfg[1] & (mc == 5'h11 || mc == 5'h14 || mc == 5'h15));
    iw = {2'h0, cfg[3] ? f[4] : f[1], f[0], 1'b0, f[0] | (f[1] & !cfg[3]), busyF, f[2],
          2'h0, f[5], mc};
    c0 = model_u.txCnt;
    model_u.issue('{mc, f[5], f[4], f[3], f[2], ptr}, {f[1], f[0]});
    repeat (2) @(posedge core_clk);
    `CHK("info word", iw, model_u.mem[ptr])
    `CHK("tag word", tagCap, model_u.mem[ptr + 13'h0001])
    `CHK("tx count", 32'(tx), 32'(model_u.txCnt - c0))
    if (tx) `CHK("tx data", own ? gen : pre, model_u.txLast)
    `CHK("data word", (tx && own) ? gen : pre, model_u.mem[ptr + 13'h0002])
    lastIw = iw;
    caseNo++;
    $display("case %0d done", caseNo);
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    runCase(4'h0, 5'h02, 6'h00);
    runCase(4'h0, 5'h10, 6'h20);
    runCase(4'h0, 5'h12, 6'h00);
    runCase(4'h0, 5'h13, 6'h20);
    runCase(4'h0, 5'h11, 6'h00);
    runCase(4'h0, 5'h14, 6'h00);
    runCase(4'h2, 5'h15, 6'h00);
    runCase(4'h0, 5'h01, 6'h01);
    runCase(4'h0, 5'h0F, 6'h12);
    runCase(4'h8, 5'h1F, 6'h12);
    runCase(4'h1, 5'h10, 6'h00);
    runCase(4'h0, 5'h12, 6'h08);
    runCase(4'h0, 5'h10, 6'h04);
    ahbXfer(1'b0, {24'h0, `TMCR_ADDR_TIMETAG}, 32'h0, rd);
    `CHK("time tag", {16'h0000, tagRef - 16'h0001}, rd)
    ahbXfer(1'b0, {24'h0, `TMCR_ADDR_STATE}, 32'h0, rd);
    `CHK("engine state", {29'h0, ST_IDLE}, rd)
    ahbXfer(1'b0, {24'h0, `TMCR_ADDR_COUNT}, 32'h0, rd);
    `CHK("record count", 32'h0000_000D, rd)
    ahbXfer(1'b1, {24'h0, `TMCR_ADDR_LASTINFO}, 32'hFFFF_FFFF, rd);
    ahbXfer(1'b0, {24'h0, `TMCR_ADDR_LASTINFO}, 32'h0, rd);
    `CHK("last info", {16'h0000, lastIw}, rd)
    ahbXfer(1'b1, {24'h0, `TMCR_ADDR_CFG}, 32'hFFFF_FFF5, rd);
    ahbXfer(1'b0, {24'h0, `TMCR_ADDR_CFG}, 32'h0, rd);
    `CHK("config", 32'h0000_0005, rd)
    ahbXfer(1'b0, 32'h0000_0020, 32'h0, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    `CHK("response", 1'b0, hresp)
    $display("register test done");
    tally_and_finish();
  end
endmodule
